// ---- arct_cfg.svh ----
// arct_cfg.svh: register offsets, field positions, reset values and
// divider counts of the auto-reload capture timer.
// assumes a byte-addressed apb slave with 8-bit paddr, one word per register.
`ifndef ARCT_CFG_SVH
`define ARCT_CFG_SVH

// register byte offsets
`define ARCT_OFF_COUNT_LOW     8'h00
`define ARCT_OFF_COUNT_HIGH    8'h04
`define ARCT_OFF_RELOAD_LOW    8'h08
`define ARCT_OFF_RELOAD_HIGH   8'h0C
`define ARCT_OFF_TIMER_CTRL    8'h10
`define ARCT_OFF_CLOCK_CTRL    8'h14
`define ARCT_OFF_IRQ_ENABLE    8'h18

// field positions in the clock control and irq enable registers
`define ARCT_CCR_LOW_SEL       0
`define ARCT_CCR_HIGH_SEL      1
`define ARCT_IER_TIMER         7

// reset values
`define ARCT_RST_BYTE          8'h00
`define ARCT_RST_WORD          16'h0000
`define ARCT_RST_TCR           8'h00

// counting limits
`define ARCT_BYTE_MAX          8'hFF
`define ARCT_WORD_MAX          16'hFFFF
`define ARCT_DIV12_LAST        4'hB
`define ARCT_EXT8_LAST         3'h7

`endif

// ---- arct_edge_sync.sv ----
// arct_edge_sync: two-flop synchroniser with a rising-edge pulse.
// assumes the input is slower than half of pclk.
`timescale 1ns/1ps
module arct_edge_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic async_in,
	output logic      rise
);
	logic meta;
	logic stable;
	logic stable_d;
	logic next_rise;

	always_comb begin
		next_rise = stable & ~stable_d;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta     <= 1'h0;
			stable   <= 1'h0;
			stable_d <= 1'h0;
			rise     <= 1'h0;
		end else begin
			meta     <= async_in;
			stable   <= meta;
			stable_d <= stable;
			rise     <= next_rise;
		end
	end
endmodule

// ---- arct_pkg.sv ----
// arct_pkg: types shared by the auto-reload capture timer.
// assumes arct_cfg.svh supplies the numeric constants.
package arct_pkg;

	// one-cycle count enables, one per clock source
	typedef struct packed {
		logic sys;
		logic div12;
		logic ext8;
		logic comp;
	} arct_ticks_t;

	// timer control register, bit 7 down to bit 0
	typedef struct packed {
		logic       tf_high;
		logic       tf_low;
		logic       low_irq_en;
		logic       capture_en;
		logic       split;
		logic       run;
		logic [1:0] xclk;
	} arct_tcr_t;

	typedef enum logic [1:0] {
		ARCT_MODE_WIDE,
		ARCT_MODE_SPLIT,
		ARCT_MODE_CAPTURE
	} arct_mode_t;

endpackage

// ---- arct_timer.sv ----
// arct_timer: 16-bit / dual 8-bit auto-reload timer with capture mode,
// registers on apb.
// assumes ext_osc_in and comp_in are asynchronous and slower than pclk/2.
// assumes software keeps split clear while capturing; capture wins if not.
//
// Function
// - counter is two separately accessible bytes
// - split bit picks one 16-bit or two 8-bit
// - synchronise external and comparator sources first
// - 16-bit wrap reloads and sets high flag
// - 16-bit overflow interrupts when timer enabled
// - low byte wrap interrupts when also enabled
// - split bytes reload from own reload byte
// - split: run gates high byte only
// - high clock: core, or external select field
// - low byte selects clock independently
// - split: each byte wrap sets its flag
// - split: interrupt on high, or either byte
// - flags cleared only by software
// - capture on comparator edge or ext/8
// - upper select bit zero picks comparator
// - capture copies count, sets high flag
// - low flag set on wrap in every mode
//
// The APB register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "arct_cfg.svh"
module arct_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ext_osc_in,
	input  wire logic        comp_in,
	output logic             timer_irq
);
	logic                   ext_rise;
	logic                   comp_rise;
	logic [3:0]             div12_cnt;
	logic [3:0]             next_div12_cnt;
	logic [2:0]             ext8_cnt;
	logic [2:0]             next_ext8_cnt;
	arct_pkg::arct_ticks_t  ticks;
	arct_pkg::arct_ticks_t  next_ticks;
	arct_pkg::arct_tcr_t    tcr;
	arct_pkg::arct_tcr_t    next_tcr;
	arct_pkg::arct_mode_t   mode;
	logic [15:0]            count;
	logic [15:0]            next_count;
	logic [15:0]            reload;
	logic [15:0]            next_reload;
	logic                   low_sel;
	logic                   next_low_sel;
	logic                   high_sel;
	logic                   next_high_sel;
	logic                   timer_ie;
	logic                   next_timer_ie;
	logic                   next_timer_irq;
	logic                   low_tick;
	logic                   high_tick;
	logic                   capture_evt;
	logic                   set_high;
	logic                   set_low;
	logic                   setup;
	logic                   wr;
	logic [7:0]             wbyte;
	logic [7:0]             rbyte;
	logic                   miss;
	logic                   next_pready;
	logic                   next_pslverr;
	logic [31:0]            next_prdata;

	// count enable of a byte: core clock, or the shared external select
	function automatic logic pick_tick(
		input logic                  core_sel,
		input logic [1:0]            xclk,
		input arct_pkg::arct_ticks_t t
	);
		logic r;
		r = t.div12;
		if (core_sel) begin
			r = t.sys;
		end else begin
			case (xclk)
				2'h1: r = t.ext8;
				2'h3: r = t.comp;
				default: r = t.div12;
			endcase
		end
		return r;
	endfunction

	function automatic logic wr_to(
		input logic       w,
		input logic [7:0] a,
		input logic [7:0] off
	);
		return w && (a == off);
	endfunction

	// a count byte at its top value wraps on its next tick
	function automatic logic byte_top(
		input logic [7:0] b
	);
		return b == `ARCT_BYTE_MAX;
	endfunction

	// asynchronous sources
	// each pin level must last one clock or an edge is lost
	arct_edge_sync u_ext_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (ext_osc_in),
		.rise     (ext_rise)
	);

	arct_edge_sync u_comp_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (comp_in),
		.rise     (comp_rise)
	);

	// clock-source enables
	// enables are registered, so a count lags its source by one clock
	// ext8_cnt moves only on synchronised rising edges of the oscillator
	always_comb begin
		next_div12_cnt = (div12_cnt == `ARCT_DIV12_LAST) ? 4'h0 : div12_cnt + 4'h1;
		next_ext8_cnt  = ext_rise ? ext8_cnt + 3'h1 : ext8_cnt;
		next_ticks.sys   = 1'h1;
		next_ticks.div12 = (div12_cnt == `ARCT_DIV12_LAST);
		next_ticks.ext8  = ext_rise && (ext8_cnt == `ARCT_EXT8_LAST);
		next_ticks.comp  = comp_rise;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div12_cnt <= 4'h0;
			ext8_cnt  <= 3'h0;
			ticks     <= 4'h0;
		end else begin
			div12_cnt <= next_div12_cnt;
			ext8_cnt  <= next_ext8_cnt;
			ticks     <= next_ticks;
		end
	end

	// mode and per-byte enables
	// capture outranks split when software sets both
	always_comb begin
		if (tcr.capture_en) begin
			mode = arct_pkg::ARCT_MODE_CAPTURE;
		end else if (tcr.split) begin
			mode = arct_pkg::ARCT_MODE_SPLIT;
		end else begin
			mode = arct_pkg::ARCT_MODE_WIDE;
		end
		low_tick    = pick_tick(low_sel, tcr.xclk, ticks);
		high_tick   = pick_tick(high_sel, tcr.xclk, ticks);
		capture_evt = tcr.capture_en && (tcr.xclk[1] ? ticks.ext8 : ticks.comp);
	end

	// apb decode
	// read data is latched in the setup cycle, the access sees that value
	// a write needs the access phase and the low byte strobe
	always_comb begin
		setup = psel && !penable;
		wr    = psel && penable && pready && pwrite && pstrb[0];
		wbyte = pwdata[7:0];
		miss  = 1'h0;
		rbyte = `ARCT_RST_BYTE;
		case (paddr)
			`ARCT_OFF_COUNT_LOW:   rbyte = count[7:0];
			`ARCT_OFF_COUNT_HIGH:  rbyte = count[15:8];
			`ARCT_OFF_RELOAD_LOW:  rbyte = reload[7:0];
			`ARCT_OFF_RELOAD_HIGH: rbyte = reload[15:8];
			`ARCT_OFF_TIMER_CTRL:  rbyte = tcr;
			`ARCT_OFF_CLOCK_CTRL: begin
				rbyte[`ARCT_CCR_LOW_SEL]  = low_sel;
				rbyte[`ARCT_CCR_HIGH_SEL] = high_sel;
			end
			`ARCT_OFF_IRQ_ENABLE: begin
				rbyte[`ARCT_IER_TIMER] = timer_ie;
			end
			default: miss = 1'h1;
		endcase
		next_pready  = setup;
		next_pslverr = setup && miss;
		next_prdata  = setup ? {24'h000000, rbyte} : prdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'h0;
			pslverr <= 1'h0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// counter, reload and overflow events
	always_comb begin
		set_high    = 1'h0;
		set_low     = 1'h0;
		next_count  = count;
		next_reload = reload;
		if (wr_to(wr, paddr, `ARCT_OFF_RELOAD_LOW)) begin
			next_reload[7:0] = wbyte;
		end
		if (wr_to(wr, paddr, `ARCT_OFF_RELOAD_HIGH)) begin
			next_reload[15:8] = wbyte;
		end
		case (mode)
			arct_pkg::ARCT_MODE_WIDE: begin
				if (tcr.run && low_tick) begin
					if (count == `ARCT_WORD_MAX) begin
						next_count = reload;
						set_high   = 1'h1;
					end else begin
						next_count = count + 16'h0001;
					end
					// the low byte wraps with the word, so its flag rises too
					if (byte_top(count[7:0])) begin
						set_low = 1'h1;
					end
				end
			end
			arct_pkg::ARCT_MODE_SPLIT: begin
				if (low_tick) begin
					if (byte_top(count[7:0])) begin
						next_count[7:0] = reload[7:0];
						set_low         = 1'h1;
					end else begin
						next_count[7:0] = count[7:0] + 8'h01;
					end
				end
				if (tcr.run && high_tick) begin
					if (byte_top(count[15:8])) begin
						next_count[15:8] = reload[15:8];
						set_high         = 1'h1;
					end else begin
						next_count[15:8] = count[15:8] + 8'h01;
					end
				end
			end
			arct_pkg::ARCT_MODE_CAPTURE: begin
				// free run: rolls over to zero, never reloaded
				if (tcr.run && low_tick) begin
					next_count = count + 16'h0001;
					if (byte_top(count[7:0])) begin
						set_low = 1'h1;
					end
				end
				// the copy takes the count before this cycle's step
				if (capture_evt) begin
					next_reload = count;
					set_high    = 1'h1;
				end
			end
			default: begin
				next_count = count;
			end
		endcase
		// a software write to a count byte overrides that cycle's increment
		if (wr_to(wr, paddr, `ARCT_OFF_COUNT_LOW)) begin
			next_count[7:0] = wbyte;
		end
		if (wr_to(wr, paddr, `ARCT_OFF_COUNT_HIGH)) begin
			next_count[15:8] = wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count  <= `ARCT_RST_WORD;
			reload <= `ARCT_RST_WORD;
		end else begin
			count  <= next_count;
			reload <= next_reload;
		end
	end

	// control registers and flags; a hardware set beats a software clear
	always_comb begin
		next_tcr      = tcr;
		next_low_sel  = low_sel;
		next_high_sel = high_sel;
		next_timer_ie = timer_ie;
		if (wr_to(wr, paddr, `ARCT_OFF_TIMER_CTRL)) begin
			next_tcr = wbyte;
		end
		if (wr_to(wr, paddr, `ARCT_OFF_CLOCK_CTRL)) begin
			next_low_sel  = wbyte[`ARCT_CCR_LOW_SEL];
			next_high_sel = wbyte[`ARCT_CCR_HIGH_SEL];
		end
		if (wr_to(wr, paddr, `ARCT_OFF_IRQ_ENABLE)) begin
			next_timer_ie = wbyte[`ARCT_IER_TIMER];
		end
		if (set_high) begin
			next_tcr.tf_high = 1'h1;
		end
		if (set_low) begin
			next_tcr.tf_low = 1'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tcr       <= `ARCT_RST_TCR;
			low_sel   <= 1'h0;
			high_sel  <= 1'h0;
			timer_ie  <= 1'h0;
		end else begin
			tcr       <= next_tcr;
			low_sel   <= next_low_sel;
			high_sel  <= next_high_sel;
			timer_ie  <= next_timer_ie;
		end
	end

	// interrupt request, one edge behind the flags and enables it follows
	always_comb begin
		next_timer_irq = timer_ie && (tcr.tf_high
			|| (tcr.low_irq_en && tcr.tf_low));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_irq <= 1'h0;
		end else begin
			timer_irq <= next_timer_irq;
		end
	end
endmodule

// ---- arct_timer_bench.sv ----
// arct_timer_bench: self-checking bench for arct_timer over apb
// assumes arct_timer_props is bound in by its own file
`timescale 1ns/1ps
module arct_timer_bench;
	logic        pclk, presetn, psel, penable, pwrite, ext_osc_in, comp_in, exp_irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r;
	logic [3:0]  pstrb;
	logic        pready, pslverr, timer_irq;
	logic [17:0] q[$];
	logic [17:0] e;
	logic [9:0]  g;
	int          error_cnt, check_count, cyc;

	arct_timer arct_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_osc_in(ext_osc_in), .comp_in(comp_in), .timer_irq(timer_irq));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task automatic wrap_up;
		if (error_cnt == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic xfer(input logic w, input logic [7:0] a, d, input logic [3:0] s = 4'hF);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// note {irq, error, mask, masked data} then read
	task automatic rd(input logic [7:0] a, m, d);
		q.push_back({exp_irq, a > 8'h18 || a[1:0] != 2'h0, m, d & m});
		xfer(1'b0, a, 8'h00);
	endtask

	// n high pulses, 6 cycles per level
	task automatic pulse(input logic ext, input int n);
		repeat (2 * n) begin
			repeat (6) @(posedge pclk);
			if (ext)
				ext_osc_in <= ~ext_osc_in;
			else
				comp_in <= ~comp_in;
		end
		repeat (6) @(posedge pclk);
	endtask

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = q.pop_front();
			g = {timer_irq, pslverr, prdata[7:0] & e[15:8]};
			check_count++;
			if (g !== {e[17:16], e[7:0]}) begin
				$display("unexpected at %0t: got %h exp %h", $time, g, {e[17:16], e[7:0]});
				error_cnt++;
			end
		end
	end

	always @(posedge pclk) begin
		if (++cyc > 20000) begin
			error_cnt++;
			wrap_up();
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
		{ext_osc_in, comp_in, exp_irq, presetn} = '0;
		{error_cnt, check_count, cyc} = '0;
		void'($urandom(32'h95FE));
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(i * 4), 8'hFF, 8'h00);
		r = $urandom;
		for (int i = 0; i < 4; i++) xfer(1'b1, 8'(i * 4), r[i*8+:8]);
		for (int i = 0; i < 4; i++) rd(8'(i * 4), 8'hFF, r[i*8+:8]);
		xfer(1'b1, 8'h04, ~r[15:8], 4'h0);
		rd(8'h04, 8'hFF, r[15:8]);
		xfer(1'b1, 8'h20, 8'h5A);
		rd(8'h1C, 8'hFF, 8'h00);
		rd(8'h01, 8'hFF, 8'h00);
		// 16-bit wrap on core clock
		xfer(1'b1, 8'h14, 8'h01);
		xfer(1'b1, 8'h18, 8'h80);
		xfer(1'b1, 8'h08, 8'h00);
		xfer(1'b1, 8'h0C, 8'h12);
		xfer(1'b1, 8'h00, 8'hF0);
		xfer(1'b1, 8'h04, 8'hFF);
		xfer(1'b1, 8'h10, 8'h04);
		repeat (40) @(posedge pclk);
		exp_irq = 1'b1;
		rd(8'h10, 8'h80, 8'h80);
		rd(8'h04, 8'hFF, 8'h12);
		xfer(1'b1, 8'h10, 8'h24);
		exp_irq = 1'b0;
		rd(8'h10, 8'hC0, 8'h00);
		repeat (300) @(posedge pclk);
		exp_irq = 1'b1;
		rd(8'h10, 8'hC0, 8'h40);
		xfer(1'b1, 8'h10, 8'h00);
		exp_irq = 1'b0;
		// split mode, high byte stopped, then run on core clock to its wrap
		xfer(1'b1, 8'h04, 8'h55);
		xfer(1'b1, 8'h00, 8'hF0);
		xfer(1'b1, 8'h08, 8'h80);
		xfer(1'b1, 8'h10, 8'h08);
		repeat (40) @(posedge pclk);
		rd(8'h04, 8'hFF, 8'h55);
		rd(8'h10, 8'hC0, 8'h40);
		rd(8'h00, 8'h80, 8'h80);
		xfer(1'b1, 8'h14, 8'h03);
		xfer(1'b1, 8'h04, 8'hFF);
		xfer(1'b1, 8'h0C, 8'h77);
		xfer(1'b1, 8'h10, 8'h0C);
		repeat (20) @(posedge pclk);
		exp_irq = 1'b1;
		rd(8'h10, 8'h80, 8'h80);
		xfer(1'b1, 8'h10, 8'h08);
		exp_irq = 1'b0;
		// high byte on comparator, then on external clock / 8
		xfer(1'b1, 8'h14, 8'h01);
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, 8'h04, 8'h10);
			xfer(1'b1, 8'h10, k ? 8'h0D : 8'h0F);
			pulse(k[0], k ? 16 : 5);
			xfer(1'b1, 8'h10, 8'h08);
			rd(8'h04, 8'hFF, k ? 8'h12 : 8'h15);
		end
		// high byte on core clock / 12 for exactly 60 edges
		xfer(1'b1, 8'h04, 8'h10);
		xfer(1'b1, 8'h10, 8'h0C);
		repeat (57) @(posedge pclk);
		xfer(1'b1, 8'h10, 8'h08);
		rd(8'h04, 8'hFF, 8'h15);
		// capture on comparator edge, then every 8 external cycles
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, 8'h0C, 8'h00);
			xfer(1'b1, 8'h04, 8'h40);
			xfer(1'b1, 8'h00, 8'h00);
			xfer(1'b1, 8'h10, k ? 8'h16 : 8'h14);
			pulse(k[0], k ? 8 : 1);
			exp_irq = 1'b1;
			rd(8'h10, 8'h80, 8'h80);
			rd(8'h0C, 8'hFF, 8'h40);
			rd(8'h04, 8'hFF, 8'h40);
			xfer(1'b1, 8'h10, 8'h00);
			exp_irq = 1'b0;
		end
		wrap_up();
	end
endmodule

// ---- arct_timer_props.sv ----
// arct_timer_props: apb handshake and interrupt checks on the arct_timer ports
// assumes it is bound into every arct_timer instance
`timescale 1ns/1ps
module arct_timer_props (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        ext_osc_in,
	input wire logic        comp_in,
	input wire logic        timer_irq
);
	wire setup = psel && !penable;
	wire bad   = paddr > 8'h18 || paddr[1:0] != 2'h0;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_ready_next: assert property (setup |=> pready)
		else $error("pready missing");
	chk_ready_once: assert property (pready |=> !pready)
		else $error("pready too long");
	chk_ready_cause: assert property (pready |-> $past(setup))
		else $error("pready without setup");
	chk_err_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	chk_err_unmap: assert property (setup && bad |=> pslverr && prdata == 32'h0)
		else $error("unmapped not refused");
	chk_err_mapped: assert property (setup && !bad |=> !pslverr)
		else $error("mapped refused");
	chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_irq_clear: assert property ($fell(timer_irq) |->
		$past(psel && penable && pwrite, 2))
		else $error("irq dropped without write");
endmodule
bind arct_timer arct_timer_props arct_timer_props_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_osc_in(ext_osc_in), .comp_in(comp_in), .timer_irq(timer_irq));
